// ==== pwc_top.sv ====
// Wiper position control: input timing, direction, mode and storage.
// Assumes synchronous pins and an external nonvolatile cell array.
module pwc_top #(
    parameter int PULSE_CYC = pwc_pkg::PULSE_MIN_CYC,
    parameter int GAP_CYC = pwc_pkg::GAP_MIN_CYC,
    parameter int HOLD_CYC = pwc_pkg::HOLD_CYC,
    parameter int REP_CYC = pwc_pkg::REPEAT_CYC,
    parameter int IDLE_CYC = pwc_pkg::IDLE_REV_CYC,
    parameter int STORE_CYC = pwc_pkg::STORE_DELAY_CYC,
    parameter int DEB_CYC = pwc_pkg::DEBOUNCE_CYC,
    parameter int STEP_CYC = pwc_pkg::STEP_MIN_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Control pins, active low
    input wire logic up_contact_input_n,
    input wire logic down_contact_input_n,
    input wire logic step_input_n,
    // Power-up strap: down input tied high
    input wire logic mode_strap_single,
    // Nonvolatile cells
    input wire logic [5:0] nv_rd_data,
    input wire logic nv_worn,
    output logic nv_wr_en,
    output logic [5:0] nv_wr_data,
    // Status
    output logic [5:0] wiper_pos,
    output logic mode_single
);
    localparam int CW = pwc_pkg::CNT_W;

    logic rst_s1_r, rst_n;
    logic init_done_r, init_done_nxt, mode_single_r, mode_single_nxt;
    logic dir_up_r, dir_up_nxt, rev_pend_r, rev_pend_nxt;
    logic [5:0] wiper_pos_r, wiper_pos_nxt;
    logic [CW-1:0] idle_r, idle_nxt;
    logic init_load, single_step, single_act, dual_up, dual_dn, eff_up;
    logic [5:0] single_pos;

    // Async assert, release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'h0;
            rst_n <= 1'h0;
        end else begin
            rst_s1_r <= 1'h1;
            rst_n <= rst_s1_r;
        end
    end

    pwc_step_if up_if ();
    pwc_step_if dn_if ();
    pwc_step_if dg_if ();

    // contact inputs get the long debounce
    pwc_pulse #(
        .DEB(DEB_CYC), .MIN_LOW(PULSE_CYC), .MIN_GAP(GAP_CYC),
        .HOLD(HOLD_CYC), .REP(REP_CYC), .CW(CW)
    ) u_up (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_n(up_contact_input_n),
        .sif(up_if)
    );

    pwc_pulse #(
        .DEB(DEB_CYC), .MIN_LOW(PULSE_CYC), .MIN_GAP(GAP_CYC),
        .HOLD(HOLD_CYC), .REP(REP_CYC), .CW(CW)
    ) u_dn (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_n(down_contact_input_n),
        .sif(dn_if)
    );

    // digital input takes microsecond pulses and gaps
    pwc_pulse #(
        .DEB(1), .MIN_LOW(STEP_CYC), .MIN_GAP(STEP_CYC),
        .HOLD(HOLD_CYC), .REP(REP_CYC), .CW(CW)
    ) u_dg (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_n(step_input_n),
        .sif(dg_if)
    );

    assign init_load = ce && !init_done_r;

    // down input ignored in single mode
    // dual mode maps the up and down contact inputs to fixed directions; the digital input still steps both ways
    assign single_step = dg_if.step || (up_if.step && mode_single_r);
    assign dual_up = up_if.step && !mode_single_r;
    assign dual_dn = dn_if.step && !mode_single_r;
    // activity that holds off the idle reversal
    assign single_act = dg_if.held || (up_if.held && mode_single_r);
    // pending reversal flips the remembered direction
    assign eff_up = rev_pend_r ? !dir_up_r : dir_up_r;

    always_comb begin
        if (eff_up) begin
            single_pos = (wiper_pos_r == pwc_pkg::POS_TOP) ? wiper_pos_r
                : wiper_pos_r + 6'h01;
        end else begin
            single_pos = (wiper_pos_r == pwc_pkg::POS_BOTTOM) ? wiper_pos_r
                : wiper_pos_r - 6'h01;
        end
    end

    always_comb begin
        init_done_nxt = init_done_r;
        mode_single_nxt = mode_single_r;
        wiper_pos_nxt = wiper_pos_r;
        dir_up_nxt = dir_up_r;
        rev_pend_nxt = rev_pend_r;
        idle_nxt = idle_r;
        if (init_load) begin
            init_done_nxt = 1'h1;
            // strap low (floating down input) means dual mode
            mode_single_nxt = mode_single_strap_of(mode_strap_single);
            wiper_pos_nxt = nv_rd_data;
        end else if (ce) begin
            if (single_act) begin
                idle_nxt = '0;
            end else if (idle_r == CW'(IDLE_CYC - 1)) begin
                rev_pend_nxt = 1'h1;
            end else begin
                idle_nxt = idle_r + CW'(1);
            end
            if (single_step) begin
                wiper_pos_nxt = single_pos;
                rev_pend_nxt = 1'h0;
                // reaching an end turns the direction
                if (single_pos == pwc_pkg::POS_TOP) begin
                    dir_up_nxt = 1'h0;
                end else if (single_pos == pwc_pkg::POS_BOTTOM) begin
                    dir_up_nxt = 1'h1;
                end else begin
                    dir_up_nxt = eff_up;
                end
            end else if (dual_up) begin
                // held at the top until a down step
                if (wiper_pos_r != pwc_pkg::POS_TOP) begin
                    wiper_pos_nxt = wiper_pos_r + 6'h01;
                end
            end else if (dual_dn) begin
                if (wiper_pos_r != pwc_pkg::POS_BOTTOM) begin
                    wiper_pos_nxt = wiper_pos_r - 6'h01;
                end
            end
        end
    end

    // Power-up direction is unknown; start down with a reversal armed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done_r <= 1'h0;
            mode_single_r <= 1'h0;
            wiper_pos_r <= pwc_pkg::POS_RST;
            dir_up_r <= 1'h0;
            rev_pend_r <= 1'h1;
            idle_r <= '0;
        end else begin
            init_done_r <= init_done_nxt;
            mode_single_r <= mode_single_nxt;
            wiper_pos_r <= wiper_pos_nxt;
            dir_up_r <= dir_up_nxt;
            rev_pend_r <= rev_pend_nxt;
            idle_r <= idle_nxt;
        end
    end

    function automatic logic mode_single_strap_of(input logic strap);
        mode_single_strap_of = strap;
    endfunction : mode_single_strap_of

    // delayed store of the live position
    pwc_nvstore #(
        .DELAY(STORE_CYC),
        .CW(CW)
    ) u_nv (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .load(init_load),
        .load_val(nv_rd_data),
        .pos(wiper_pos_r),
        .worn(nv_worn),
        .wr_en(nv_wr_en),
        .wr_data(nv_wr_data)
    );

    assign wiper_pos = wiper_pos_r;
    assign mode_single = mode_single_r;

    // edges the wiper has stood still
    // Kept apart from the store timer so a miscount there shows up
    logic [5:0] pos_last_r, pos_last_nxt;
    logic [CW-1:0] still_r, still_nxt;

    always_comb begin
        pos_last_nxt = pos_last_r;
        still_nxt = still_r;
        if (ce) begin
            pos_last_nxt = wiper_pos_r;
            if (wiper_pos_r != pos_last_r) begin
                still_nxt = '0;
            end else if (still_r != CW'(STORE_CYC)) begin
                still_nxt = still_r + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_last_r <= pwc_pkg::POS_RST;
            still_r <= '0;
        end else begin
            pos_last_r <= pos_last_nxt;
            still_r <= still_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    mode_strap_a: assert property (init_load |=> mode_single_r == $past(mode_strap_single))
        else $error("Mode not taken from strap");
    mode_hold_a: assert property (init_done_r |=> $stable(mode_single_r))
        else $error("Mode changed after power-up");
    pos_restore_a: assert property (init_load |=> wiper_pos_r == $past(nv_rd_data))
        else $error("Position not restored at power-up");
    one_step_a: assert property (init_done_r |=> wiper_pos_r == $past(wiper_pos_r)
        || wiper_pos_r == $past(wiper_pos_r) + 6'h01
        || wiper_pos_r == $past(wiper_pos_r) - 6'h01)
        else $error("Wiper moved more than one tap");
    pos_sat_a: assert property (init_done_r && wiper_pos_r == pwc_pkg::POS_TOP
        && !single_step && !dual_dn |=> wiper_pos_r == pwc_pkg::POS_TOP)
        else $error("Wiper wrapped past the top");
    dual_up_a: assert property (ce && init_done_r && dual_up && !single_step
        && wiper_pos_r != pwc_pkg::POS_TOP |=> wiper_pos_r == $past(wiper_pos_r) + 6'h01)
        else $error("Dual up step missing");
    dc_ignored_a: assert property (ce && init_done_r && mode_single_r
        && !single_step |=> $stable(wiper_pos_r))
        else $error("Down input moved wiper in single mode");
    end_reverse_a: assert property (ce && init_done_r && single_step
        && single_pos == pwc_pkg::POS_TOP |=> !dir_up_r && !rev_pend_r)
        else $error("No reversal at top end");
    idle_reverse_a: assert property (ce && init_done_r && !single_act && !single_step
        && idle_r == CW'(IDLE_CYC - 1) |=> rev_pend_r)
        else $error("Idle reversal not armed");


    // Lower end, down steps and dual-mode direction
    pos_floor_a: assert property (init_done_r && wiper_pos_r == pwc_pkg::POS_BOTTOM
        && !single_step && !dual_up |=> wiper_pos_r == pwc_pkg::POS_BOTTOM)
        else $error("Wiper wrapped past the bottom");
    dual_down_a: assert property (ce && init_done_r && dual_dn && !single_step
        && !dual_up && wiper_pos_r != pwc_pkg::POS_BOTTOM
        |=> wiper_pos_r == $past(wiper_pos_r) - 6'h01)
        else $error("Dual down step missing");
    dual_steady_a: assert property (ce && init_done_r && !mode_single_r && !single_step
        |=> $stable(dir_up_r))
        else $error("Direction turned in dual mode");

    // Direction in single-button rules
    low_reverse_a: assert property (ce && init_done_r && single_step
        && single_pos == pwc_pkg::POS_BOTTOM |=> dir_up_r && !rev_pend_r)
        else $error("No reversal at bottom end");
    pause_reverse_a: assert property (ce && init_done_r && single_step && rev_pend_r
        && !dir_up_r && wiper_pos_r != pwc_pkg::POS_TOP
        |=> wiper_pos_r == $past(wiper_pos_r) + 6'h01)
        else $error("First move did not reverse");
    digital_dual_a: assert property (ce && init_done_r && !mode_single_r && dg_if.step
        && wiper_pos_r != pwc_pkg::POS_TOP && wiper_pos_r != pwc_pkg::POS_BOTTOM
        |=> wiper_pos_r != $past(wiper_pos_r))
        else $error("Digital step ignored in dual mode");

    // Enable and storage
    enable_freeze_a: assert property (!ce && init_done_r |=> $stable(wiper_pos_r)
        && $stable(dir_up_r) && $stable(rev_pend_r) && $stable(idle_r))
        else $error("State moved with the enable low");
    store_wait_a: assert property (nv_wr_en |-> still_r == CW'(STORE_CYC))
        else $error("Store issued before the delay ran out");

    dual_top_c: cover property (ce && dual_up && wiper_pos_r == pwc_pkg::POS_TOP);
    single_turn_c: cover property (ce && single_step && rev_pend_r);
    nv_store_c: cover property (nv_wr_en);
    single_floor_c: cover property (ce && single_step && single_pos == pwc_pkg::POS_BOTTOM);
    digital_end_c: cover property (ce && dg_if.step && !mode_single_r
        && single_pos == pwc_pkg::POS_TOP);
endmodule : pwc_top

// ==== pwc_pkg.sv ====
// Constants, timing counts and types for the pushbutton wiper control.
// Assumes a single 100 MHz clock and synchronous pin inputs.
package pwc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int POS_W = 6;
    localparam int CNT_W = 28;
    localparam int STORE_BIT = 3;
    localparam logic [5:0] POS_TOP = 6'h3F;
    localparam logic [5:0] POS_BOTTOM = 6'h00;
    localparam logic [5:0] POS_RST = 6'h00;
    localparam int PULSE_MIN_MS = 1;
    localparam int GAP_MIN_MS = 1;
    localparam int HOLD_MS = 1000;
    localparam int REPEAT_MS = 100;
    localparam int IDLE_REV_MS = 1000;
    localparam int STORE_DELAY_MS = 2000;
    localparam int STEP_MIN_US = 1;
    localparam int DEBOUNCE_US = 500;
    // all counts derive from the clock rate
    localparam int PULSE_MIN_CYC = PULSE_MIN_MS * CYC_PER_MS;
    localparam int GAP_MIN_CYC = GAP_MIN_MS * CYC_PER_MS;
    localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
    localparam int REPEAT_CYC = REPEAT_MS * CYC_PER_MS;
    localparam int IDLE_REV_CYC = IDLE_REV_MS * CYC_PER_MS;
    localparam int STORE_DELAY_CYC = STORE_DELAY_MS * CYC_PER_MS;
    localparam int STEP_MIN_CYC = STEP_MIN_US * CYC_PER_US;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CYC_PER_US;
    typedef enum logic [1:0] {PS_IDLE, PS_LOW, PS_GAP} pwc_pstate_e;
endpackage : pwc_pkg

// ==== pwc_step_if.sv ====
// Step and hold indications from one input conditioner.
// Assumes one clock domain shared by source and sink.
interface pwc_step_if;
    logic step;
    logic held;
    modport src (output step, output held);
    modport dst (input step, input held);
endinterface : pwc_step_if

// ==== pwc_pulse.sv ====
// Debounce and pulse-width timing for one active-low control input.
// Assumes the input is synchronous to clk.
module pwc_pulse #(
    parameter int DEB = 1,
    parameter int MIN_LOW = 2,
    parameter int MIN_GAP = 2,
    parameter int HOLD = 8,
    parameter int REP = 2,
    parameter int CW = 28
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Active-low input pin
    input wire logic in_n,
    // Step indications
    pwc_step_if.src sif
);
    logic filt_r, filt_nxt, step_r, step_nxt;
    logic [CW-1:0] deb_r, deb_nxt, cnt_r, cnt_nxt, gap_r, gap_nxt;
    pwc_pkg::pwc_pstate_e st_r, st_nxt;

    always_comb begin
        filt_nxt = filt_r;
        deb_nxt = deb_r;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        gap_nxt = gap_r;
        step_nxt = step_r;
        if (ce) begin
            step_nxt = 1'h0;
            // level must hold DEB cycles to count
            if (in_n == filt_r) begin
                deb_nxt = '0;
            end else if (deb_r == CW'(DEB - 1)) begin
                filt_nxt = in_n;
                deb_nxt = '0;
            end else begin
                deb_nxt = deb_r + CW'(1);
            end
            case (st_r)
                pwc_pkg::PS_IDLE: begin
                    if (!filt_r) begin
                        st_nxt = pwc_pkg::PS_LOW;
                        cnt_nxt = '0;
                    end
                end
                pwc_pkg::PS_LOW: begin
                    if (filt_r) begin
                        st_nxt = pwc_pkg::PS_GAP;
                        gap_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + CW'(1);
                        // one step once width passes minimum
                        if (cnt_nxt == CW'(MIN_LOW)) begin
                            step_nxt = 1'h1;
                        end
                        // rewind keeps steps REP apart after hold
                        if (cnt_nxt == CW'(HOLD)) begin
                            step_nxt = 1'h1;
                            cnt_nxt = CW'(HOLD - REP);
                        end
                    end
                end
                pwc_pkg::PS_GAP: begin
                    // short gap resumes the same pulse
                    if (!filt_r) begin
                        st_nxt = pwc_pkg::PS_LOW;
                    end else if (gap_r == CW'(MIN_GAP - 1)) begin
                        st_nxt = pwc_pkg::PS_IDLE;
                    end else begin
                        gap_nxt = gap_r + CW'(1);
                    end
                end
                default: st_nxt = pwc_pkg::PS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_r <= 1'h1;
            deb_r <= '0;
            st_r <= pwc_pkg::PS_IDLE;
            cnt_r <= '0;
            gap_r <= '0;
            step_r <= 1'h0;
        end else begin
            filt_r <= filt_nxt;
            deb_r <= deb_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            gap_r <= gap_nxt;
            step_r <= step_nxt;
        end
    end

    assign sif.step = step_r;
    assign sif.held = (st_r != pwc_pkg::PS_IDLE);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    min_width_a: assert property (ce && st_r == pwc_pkg::PS_LOW && !filt_r
        && cnt_r == CW'(MIN_LOW - 1) |=> step_r)
        else $error("No step at minimum pulse width");
    idle_quiet_a: assert property (ce && st_r == pwc_pkg::PS_IDLE |=> !step_r)
        else $error("Step without a falling edge");
    gap_merge_a: assert property (ce && st_r == pwc_pkg::PS_GAP && !filt_r
        |=> st_r == pwc_pkg::PS_LOW && cnt_r == $past(cnt_r))
        else $error("Short gap did not merge pulses");
endmodule : pwc_pulse

// ==== pwc_nvstore.sv ====
// Store scheduler for the nonvolatile copy of the wiper position.
// Assumes the cells take one write pulse with data held that cycle.
module pwc_nvstore #(
    parameter int DELAY = 4,
    parameter int CW = 28
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Power-up load
    input wire logic load,
    input wire logic [5:0] load_val,
    // Live position and cell health
    input wire logic [5:0] pos,
    input wire logic worn,
    // Write port to the cells
    output logic wr_en,
    output logic [5:0] wr_data
);
    logic [5:0] stored_r, stored_nxt, prev_r, prev_nxt;
    logic first_r, first_nxt, wr_r, wr_nxt, want;
    logic [CW-1:0] cnt_r, cnt_nxt;

    // later ones only when bit 3 moves
    assign want = (pos != stored_r) && (!first_r
        || pos[pwc_pkg::STORE_BIT] != stored_r[pwc_pkg::STORE_BIT]);

    always_comb begin
        stored_nxt = stored_r;
        prev_nxt = prev_r;
        first_nxt = first_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        if (ce) begin
            wr_nxt = 1'h0;
            prev_nxt = pos;
            if (load) begin
                stored_nxt = load_val;
                first_nxt = 1'h0;
                cnt_nxt = '0;
            end else if (pos != prev_r) begin
                cnt_nxt = '0;
            end else if (want && !worn) begin
                if (cnt_r == CW'(DELAY - 1)) begin
                    wr_nxt = 1'h1;
                    stored_nxt = pos;
                    first_nxt = 1'h1;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + CW'(1);
                end
            end else begin
                cnt_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stored_r <= pwc_pkg::POS_RST;
            prev_r <= pwc_pkg::POS_RST;
            first_r <= 1'h0;
            cnt_r <= '0;
            wr_r <= 1'h0;
        end else begin
            stored_r <= stored_nxt;
            prev_r <= prev_nxt;
            first_r <= first_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
        end
    end

    assign wr_en = wr_r;
    assign wr_data = stored_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    store_delay_a: assert property (ce && !load && want && !worn && pos == prev_r
        && cnt_r == CW'(DELAY - 1) |=> wr_en && wr_data == $past(pos))
        else $error("Store missing after delay");
    store_bit3_a: assert property (ce && first_r && pos[3] == stored_r[3] |=> !wr_en)
        else $error("Store without bit 3 change");
    worn_quiet_a: assert property (ce && worn |=> !wr_en)
        else $error("Write issued to worn cells");
endmodule : pwc_nvstore

// ==== pwc_button_model.sv ====
// Behavioural pushbuttons and processor driving the three control pins.
// Assumes the bench calls the pulse task from one process at a time.
module pwc_button_model (
    // Clock
    input wire logic clk,
    // Active-low pins, idle high
    output logic up_n,
    output logic down_n,
    output logic step_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // released pins sit at the pull-up level
    initial begin
        up_n = 1'b1;
        down_n = 1'b1;
        step_n = 1'b1;
    end

    // caller sets low time and high gap
    task automatic pulse(input int sel, input int low_cyc, input int gap_cyc);
        @(negedge clk);
        case (sel)
            0: up_n = 1'b0;
            1: down_n = 1'b0;
            default: step_n = 1'b0;
        endcase
        repeat (low_cyc) @(negedge clk);
        up_n = 1'b1;
        down_n = 1'b1;
        step_n = 1'b1;
        // Next call adds one more falling edge to the gap
        repeat (gap_cyc - 1) @(negedge clk);
    endtask : pulse
endmodule : pwc_button_model

// ==== pushbutton_wiper_control_test.sv ====
// Self-checking bench for the wiper control top level.
// Assumes the shortened timing counts given to the design below.
module pushbutton_wiper_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    `define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
        $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); n_errors++; end end

    logic clk;
    logic nrst;
    logic ce;
    logic strap;
    logic [5:0] nv_rd;
    logic worn;
    logic wr_en;
    logic [5:0] wr_data;
    logic [5:0] pos;
    logic single;
    logic up_n;
    logic down_n;
    logic step_n;
    logic [5:0] exp_pos;
    logic [5:0] last_wr;
    int n_wr;
    int n_errors;
    int cmp_count;

    // Shortened timing so every scenario fits a short run
    localparam int T_PULSE = 4;
    localparam int T_GAP = 4;
    localparam int T_HOLD = 40;
    localparam int T_REP = 8;
    localparam int T_IDLE = 40;
    localparam int T_STORE = 50;
    localparam int T_DEB = 2;
    localparam int T_STEP = 2;

    pwc_top #(
        .PULSE_CYC(T_PULSE), .GAP_CYC(T_GAP), .HOLD_CYC(T_HOLD), .REP_CYC(T_REP),
        .IDLE_CYC(T_IDLE), .STORE_CYC(T_STORE), .DEB_CYC(T_DEB), .STEP_CYC(T_STEP)
    ) u_pwc_top (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .up_contact_input_n(up_n),
        .down_contact_input_n(down_n),
        .step_input_n(step_n),
        .mode_strap_single(strap),
        .nv_rd_data(nv_rd),
        .nv_worn(worn),
        .nv_wr_en(wr_en),
        .nv_wr_data(wr_data),
        .wiper_pos(pos),
        .mode_single(single)
    );

    pwc_button_model u_pwc_button_model (
        .clk(clk),
        .up_n(up_n),
        .down_n(down_n),
        .step_n(step_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Write pulses sampled once settled
    always @(negedge clk) begin
        if (wr_en === 1'b1) begin
            n_wr++;
            last_wr = wr_data;
        end
    end

    function automatic logic [5:0] step_to(input logic [5:0] p, input bit up);
        if (up) return (p == 6'h3F) ? p : p + 6'h01;
        return (p == 6'h00) ? p : p - 6'h01;
    endfunction : step_to

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic do_reset(input bit s, input logic [5:0] v, input bit w);
        @(negedge clk);
        nrst = 1'b0;
        strap = s;
        nv_rd = v;
        worn = w;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        exp_pos = v;
        `CHK("wiper_pos load", exp_pos, pos)
        `CHK("mode_single", s, single)
    endtask : do_reset

    // Gap of 14 keeps pulses separate yet under the idle reversal time
    task automatic press(input int sel, input int low, input int mv);
        u_pwc_button_model.pulse(sel, low, 14);
        if (mv > 0) exp_pos = step_to(exp_pos, 1'b1);
        else if (mv < 0) exp_pos = step_to(exp_pos, 1'b0);
        `CHK("wiper_pos", exp_pos, pos)
    endtask : press

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        int s;
        int k;
        n_errors = 0;
        cmp_count = 0;
        n_wr = 0;
        last_wr = 6'h00;
        nrst = 1'b0;
        ce = 1'b1;
        strap = 1'b0;
        nv_rd = 6'h05;
        worn = 1'b0;
        s = $urandom(32'h1f52);
        do_reset(1'b0, 6'h05, 1'b0);
        press(0, 10, 1);
        repeat (60) @(negedge clk);
        `CHK("store count", 1, n_wr)
        `CHK("store data", 6'h06, last_wr)
        press(1, 10, -1);
        press(0, 1, 0);
        press(0, 3, 0);
        u_pwc_button_model.pulse(0, 6, 3);
        press(0, 6, 1);
        repeat (60) @(negedge clk);
        `CHK("store count", 1, n_wr)
        u_pwc_button_model.pulse(0, 68, 14);
        exp_pos = exp_pos + 6'h05;
        `CHK("wiper_pos hold", exp_pos, pos)
        repeat (60) @(negedge clk);
        `CHK("store count", 2, n_wr)
        `CHK("store data", exp_pos, last_wr)
        repeat (12) begin
            s = $urandom_range(0, 1);
            press(s, $urandom_range(8, 30), (s == 0) ? 1 : -1);
        end
        do_reset(1'b0, 6'h3E, 1'b1);
        k = n_wr;
        repeat (3) press(0, 10, 1);
        press(1, 10, -1);
        press(2, 6, 1);
        repeat (60) @(negedge clk);
        `CHK("worn writes", k, n_wr)
        ce = 1'b0;
        press(0, 10, 0);
        ce = 1'b1;
        do_reset(1'b1, 6'h02, 1'b0);
        press(1, 10, 0);
        press(0, 10, 1);
        press(0, 10, 1);
        repeat (60) @(negedge clk);
        press(0, 10, -1);
        press(2, 6, -1);
        press(0, 10, -1);
        press(0, 10, -1);
        press(0, 10, 1);
        tally_and_finish();
    end
endmodule : pushbutton_wiper_control_test
